// ==== i2cme_map.svh ====
// Purpose: register offsets, field positions, reset values, timing
// Assumes: included by bare name
// Notes: APB byte addresses, one 32-bit word each
`ifndef I2CME_MAP_SVH
`define I2CME_MAP_SVH

`define I2CME_OFF_CTRL 8'h00
`define I2CME_OFF_STAT 8'h04
`define I2CME_OFF_OWN 8'h08
`define I2CME_OFF_DATA 8'h0C

`define I2CME_CTRL_EN 0
`define I2CME_CTRL_MSTA 1
`define I2CME_CTRL_TX 2
`define I2CME_CTRL_NOACK 3
`define I2CME_CTRL_RSTA 4

`define I2CME_STAT_DONE 0
`define I2CME_STAT_BUSY 1
`define I2CME_STAT_ADDR 2
`define I2CME_STAT_ARBL 3
`define I2CME_STAT_SRW 4
`define I2CME_STAT_NACK 5
`define I2CME_STAT_IRQ 6
`define I2CME_STAT_MSTR 7

`define I2CME_CTRL_RST 4'h0
`define I2CME_OWN_RST 7'h00

`define I2CME_SYS_HZ 50000000
`define I2CME_SCL_HZ 100000
`define I2CME_QUARTERS 4

`endif

// ==== i2cme_pkg.sv ====
// Purpose: shared types of the two-wire bus engine
// Assumes: nothing
// Notes: master sequencer states are one-hot
package i2cme_pkg;

   typedef enum logic [7:0] {
      M_IDLE = 8'h01,
      M_START = 8'h02,
      M_LOW = 8'h04,
      M_HIGH = 8'h08,
      M_STOPL = 8'h10,
      M_STOPH = 8'h20,
      M_RSTL = 8'h40,
      M_RSTH = 8'h80
   } i2cme_mstate_t;

   typedef struct packed {
      logic noack;
      logic tx;
      logic msta;
      logic en;
   } i2cme_ctrl_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } i2cme_line_t;

endpackage : i2cme_pkg

// ==== i2cme_sync.sv ====
// Purpose: two-flop synchroniser per bit
// Assumes: inputs asynchronous to clk
// Notes: idles high like a pulled-up line
module i2cme_sync #(
   parameter int unsigned WIDTH = 2
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   if (WIDTH < 1) begin : g_bad
      $error("WIDTH must be at least 1");
   end
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      always_ff @(posedge clk) begin
         if (srst) begin
            meta_q <= 1'h1;
            q[i] <= 1'h1;
         end else begin
            meta_q <= d[i];
            q[i] <= meta_q;
         end
      end
   end
endmodule : i2cme_sync

// ==== i2cme_tick.sv ====
// Purpose: quarter-bit tick divider
// Assumes: clr restarts a full period
// Notes: tick is a one-cycle pulse every DIV cycles
module i2cme_tick #(
   parameter int unsigned DIV = 125
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic clr,
   output logic tick
);
   localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   logic [CW-1:0] cnt_q;

   if (DIV < 2) begin : g_bad
      $error("DIV must be at least 2");
   end

   always_ff @(posedge clk) begin
      if (srst || clr || cnt_q == LAST) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 1'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         tick <= 1'h0;
      end else begin
         tick <= !clr && cnt_q == LAST;
      end
   end
endmodule : i2cme_tick

// ==== i2cme_engine.sv ====
// Purpose: two-wire master/slave bus engine with APB registers
// Assumes: open-drain pads outside, srst synchronous
// Notes: master, or an addressed slave unless its sent byte got a NACK, holds the clock low after each byte
// until the data register is accessed or the master begins a STOP or repeated START
//
// Our own choices: the register addresses and the APB slave port.
`include "i2cme_map.svh"

module i2cme_engine
   import i2cme_pkg::*;
#(
   parameter int unsigned SYS_CLK_HZ = `I2CME_SYS_HZ,
   parameter int unsigned SCL_HZ = `I2CME_SCL_HZ
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_sense,
   output logic scl_level,
   output logic scl_oe,
   input wire logic sda_sense,
   output logic sda_level,
   output logic sda_oe,
   output logic irq_n,
   output logic byte_done_flag
);
   localparam int unsigned QDIV = (SYS_CLK_HZ + SCL_HZ * `I2CME_QUARTERS - 1) /
      (SCL_HZ * `I2CME_QUARTERS);

   if (SCL_HZ == 0 || QDIV < 2) begin : g_bad
      $error("system clock too slow for the bus clock");
   end

   i2cme_line_t line_s;
   i2cme_line_t line_p_q;
   i2cme_ctrl_t ctrl_q;
   i2cme_mstate_t m_state_q;
   i2cme_mstate_t m_state_d;
   logic [6:0] own_q;
   logic [7:0] sh_q;
   logic [7:0] rx_q;
   logic [3:0] bit_q;
   logic first_q, busy_q, master_q, addressed_q, srw_q, rx_nack_q;
   logic arb_lost_q, irq_pend_q, byte_done_q, hold_q, ph_q;
   logic start_req_q, stop_req_q, rs_req_q;
   logic tick, tick_clr, ph_done;
   logic scl_rise, scl_fall, start_det, stop_det, bus_free;
   logic tx_act, drv, lost, call_hit, ninth_fall, start_take, start_fail, frame_rise, load_ok;
   logic acc, wr, rd_data, wr_data, wr_ctrl, wr_stat;
   logic [31:0] rdata;

   i2cme_sync #(.WIDTH(2)) u_sync (
      .clk(clk),
      .srst(srst),
      .d({scl_sense, sda_sense}),
      .q(line_s)
   );

   i2cme_tick #(.DIV(QDIV)) u_tick (
      .clk(clk),
      .srst(srst),
      .clr(tick_clr),
      .tick(tick)
   );

   // Bus condition detection on synchronised levels
   always_ff @(posedge clk) begin
      if (srst) begin
         line_p_q <= 2'h3;
      end else begin
         line_p_q <= line_s;
      end
   end

   assign scl_rise = line_s.scl && !line_p_q.scl;
   assign scl_fall = !line_s.scl && line_p_q.scl;
   assign start_det = line_s.scl && line_p_q.scl && line_p_q.sda && !line_s.sda;
   assign stop_det = line_s.scl && line_p_q.scl && !line_p_q.sda && line_s.sda;
   assign bus_free = !busy_q && line_s.scl && line_s.sda;

   // APB slave, one wait state
   assign acc = psel && penable && pready;
   assign wr = acc && pwrite;
   assign wr_ctrl = wr && paddr == `I2CME_OFF_CTRL;
   assign wr_stat = wr && paddr == `I2CME_OFF_STAT;
   assign wr_data = wr && paddr == `I2CME_OFF_DATA;
   assign rd_data = acc && !pwrite && paddr == `I2CME_OFF_DATA;

   always_comb begin
      rdata = 32'h0;
      case (paddr)
         `I2CME_OFF_CTRL: rdata[3:0] = ctrl_q;
         `I2CME_OFF_STAT: begin
            rdata[`I2CME_STAT_DONE] = byte_done_q;
            rdata[`I2CME_STAT_BUSY] = busy_q;
            rdata[`I2CME_STAT_ADDR] = addressed_q;
            rdata[`I2CME_STAT_ARBL] = arb_lost_q;
            rdata[`I2CME_STAT_SRW] = srw_q;
            rdata[`I2CME_STAT_NACK] = rx_nack_q;
            rdata[`I2CME_STAT_IRQ] = irq_pend_q;
            rdata[`I2CME_STAT_MSTR] = master_q;
         end
         `I2CME_OFF_OWN: rdata[7:1] = own_q;
         `I2CME_OFF_DATA: rdata[7:0] = rx_q;
         default: rdata = 32'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pready <= 1'h0;
         prdata <= 32'h0;
         pslverr <= 1'h0;
      end else begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready) begin
            prdata <= pwrite ? 32'h0 : rdata;
            pslverr <= paddr != `I2CME_OFF_CTRL && paddr != `I2CME_OFF_STAT &&
               paddr != `I2CME_OFF_OWN && paddr != `I2CME_OFF_DATA;
         end
      end
   end

   // Transfer direction and the level to put on the data line
   assign tx_act = first_q ? master_q : (master_q ? ctrl_q.tx : (addressed_q && srw_q));
   always_comb begin
      if (bit_q < 4'h8) begin
         drv = tx_act && !sh_q[7];
      end else if (first_q) begin
         drv = addressed_q && !master_q;
      end else begin
         drv = !tx_act && (master_q || addressed_q) && !ctrl_q.noack;
      end
   end

   // Data rises only; the rise before a repeated START or STOP is not a bit
   assign frame_rise = scl_rise && busy_q && bit_q < 4'h8 && m_state_q != M_RSTH && m_state_q != M_STOPH;
   assign lost = frame_rise && master_q && tx_act && !sda_oe && !line_s.sda;
   assign ninth_fall = scl_fall && busy_q && bit_q == 4'h8;
   assign call_hit = scl_fall && busy_q && first_q && bit_q == 4'h7 &&
      sh_q[7:1] == own_q && !master_q;
   assign start_take = m_state_q == M_IDLE && ctrl_q.en && start_req_q && bus_free;
   assign start_fail = m_state_q == M_IDLE && start_req_q && !bus_free;
   // Next byte may be loaded while held or while a repeated START runs
   assign load_ok = !busy_q || hold_q ||
      master_q && (m_state_q == M_RSTL || m_state_q == M_RSTH || m_state_q == M_START);

   // Control register and master requests
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_q <= `I2CME_CTRL_RST;
         own_q <= `I2CME_OWN_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl_q.en <= pwdata[`I2CME_CTRL_EN];
            ctrl_q.msta <= pwdata[`I2CME_CTRL_MSTA];
            ctrl_q.tx <= pwdata[`I2CME_CTRL_TX];
            ctrl_q.noack <= pwdata[`I2CME_CTRL_NOACK];
         end
         if (lost || start_fail || call_hit) begin
            ctrl_q.msta <= 1'h0;
         end
         if (wr && paddr == `I2CME_OFF_OWN) begin
            own_q <= pwdata[7:1];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst || !master_q && !start_req_q && !wr_ctrl) begin
         start_req_q <= 1'h0;
         stop_req_q <= 1'h0;
         rs_req_q <= 1'h0;
      end else begin
         if (wr_ctrl && pwdata[`I2CME_CTRL_MSTA] && !ctrl_q.msta) begin
            start_req_q <= 1'h1;
         end else if (start_take || start_fail) begin
            start_req_q <= 1'h0;
         end
         if (wr_ctrl && !pwdata[`I2CME_CTRL_MSTA] && master_q) begin
            stop_req_q <= 1'h1;
         end else if (m_state_q == M_STOPL || !master_q) begin
            stop_req_q <= 1'h0;
         end
         if (wr_ctrl && pwdata[`I2CME_CTRL_RSTA] && master_q) begin
            rs_req_q <= 1'h1;
         end else if (m_state_q == M_RSTL || !master_q) begin
            rs_req_q <= 1'h0;
         end
      end
   end

   // Master sequencer
   assign ph_done = tick && ph_q;
   always_comb begin
      m_state_d = m_state_q;
      case (m_state_q)
         M_IDLE: if (start_take) m_state_d = M_START;
         M_START: if (ph_done) m_state_d = M_LOW;
         M_LOW: begin
            if (ph_done && hold_q && stop_req_q) begin
               m_state_d = M_STOPL;
            end else if (ph_done && hold_q && rs_req_q) begin
               m_state_d = M_RSTL;
            end else if (ph_done && !hold_q) begin
               m_state_d = M_HIGH;
            end
         end
         M_HIGH: if (ph_done || scl_fall) m_state_d = M_LOW;
         M_STOPL: if (ph_done) m_state_d = M_STOPH;
         M_STOPH: if (ph_done) m_state_d = M_IDLE;
         M_RSTL: if (ph_done) m_state_d = M_RSTH;
         M_RSTH: if (ph_done) m_state_d = M_START;
         default: m_state_d = M_IDLE;
      endcase
      if (m_state_q != M_IDLE && (lost || !master_q || !ctrl_q.en)) begin
         m_state_d = M_IDLE;
      end
   end

   // High phases count only once the line is really high
   assign tick_clr = m_state_d != m_state_q ||
      (m_state_q == M_HIGH || m_state_q == M_STOPH || m_state_q == M_RSTH) && !line_s.scl;

   always_ff @(posedge clk) begin
      if (srst) begin
         m_state_q <= M_IDLE;
         ph_q <= 1'h0;
      end else begin
         m_state_q <= m_state_d;
         ph_q <= tick_clr ? 1'h0 : (ph_q ^ tick);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         master_q <= 1'h0;
      end else if (start_take) begin
         master_q <= 1'h1;
      end else if (lost || !ctrl_q.en || m_state_q == M_STOPH && ph_done ||
            stop_det && m_state_q != M_STOPH) begin
         master_q <= 1'h0;
      end
   end

   // Bus state, bit counter, shifter
   always_ff @(posedge clk) begin
      if (srst || stop_det) begin
         busy_q <= 1'h0;
         first_q <= 1'h0;
         bit_q <= 4'h0;
      end else if (start_det) begin
         busy_q <= 1'h1;
         first_q <= 1'h1;
         // Fall that ends START wraps this to bit zero
         bit_q <= 4'hF;
      end else if (ninth_fall) begin
         first_q <= 1'h0;
         bit_q <= 4'h0;
      end else if (scl_fall && busy_q) begin
         bit_q <= bit_q + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sh_q <= 8'h00;
         rx_q <= 8'h00;
         rx_nack_q <= 1'h0;
      end else begin
         if (wr_data && load_ok) begin
            sh_q <= pwdata[7:0];
         end else if (frame_rise) begin
            sh_q <= {sh_q[6:0], line_s.sda};
         end
         if (scl_rise && busy_q && bit_q == 4'h8) begin
            rx_nack_q <= line_s.sda;
         end
         if (ninth_fall) begin
            rx_q <= sh_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst || stop_det || start_det || !ctrl_q.en) begin
         addressed_q <= 1'h0;
         srw_q <= 1'h0;
      end else if (call_hit) begin
         addressed_q <= 1'h1;
         srw_q <= sh_q[0];
      end
   end

   // Clock stretch after each byte, except a slave's sent byte that got a NACK, until software services it
   always_ff @(posedge clk) begin
      if (srst || start_det || stop_det || lost) begin
         hold_q <= 1'h0;
      end else if (ninth_fall) begin
         hold_q <= master_q || addressed_q && !(tx_act && rx_nack_q);
      end else if ((wr_data || rd_data) && !stop_req_q && !rs_req_q || m_state_q == M_STOPL ||
            m_state_q == M_RSTL) begin
         hold_q <= 1'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || start_det) begin
         byte_done_q <= 1'h0;
      end else if (ninth_fall) begin
         byte_done_q <= 1'h1;
      end else if (wr_data || rd_data || scl_rise && busy_q && bit_q == 4'h0) begin
         byte_done_q <= 1'h0;
      end
   end

   // Sticky flags, set wins over software clear
   always_ff @(posedge clk) begin
      if (srst) begin
         arb_lost_q <= 1'h0;
         irq_pend_q <= 1'h0;
      end else begin
         if (lost || start_fail) begin
            arb_lost_q <= 1'h1;
         end else if (wr_stat && pwdata[`I2CME_STAT_ARBL]) begin
            arb_lost_q <= 1'h0;
         end
         if (lost || start_fail || call_hit || ninth_fall) begin
            irq_pend_q <= 1'h1;
         end else if (wr_stat && pwdata[`I2CME_STAT_IRQ]) begin
            irq_pend_q <= 1'h0;
         end
      end
   end

   // Pad drive: low or released only
   always_ff @(posedge clk) begin
      if (srst) begin
         scl_oe <= 1'h0;
         sda_oe <= 1'h0;
         scl_level <= 1'h0;
         sda_level <= 1'h0;
         irq_n <= 1'h1;
         byte_done_flag <= 1'h0;
      end else begin
         scl_level <= 1'h0;
         sda_level <= 1'h0;
         scl_oe <= m_state_d == M_LOW || m_state_d == M_STOPL || m_state_d == M_RSTL ||
            hold_q && addressed_q && !master_q;
         if (m_state_d == M_START || m_state_d == M_STOPL || m_state_d == M_STOPH) begin
            sda_oe <= 1'h1;
         end else if (m_state_d == M_RSTL || m_state_d == M_RSTH || !ctrl_q.en || lost) begin
            sda_oe <= 1'h0;
         end else if (!line_s.scl) begin
            sda_oe <= drv;
         end else if (!master_q && !addressed_q) begin
            sda_oe <= 1'h0;
         end
         irq_n <= !irq_pend_q;
         byte_done_flag <= byte_done_q;
      end
   end

endmodule : i2cme_engine

// ==== i2cme_chk_assertions.sv ====
// Purpose: port checks of the two-wire bus engine
// Assumes: bound to every i2cme_engine
// Notes: quarter worked out as in the engine
module i2cme_chk #(
   parameter int unsigned SYS_CLK_HZ = 50000000,
   parameter int unsigned SCL_HZ = 100000
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_sense,
   input wire logic scl_level,
   input wire logic scl_oe,
   input wire logic sda_sense,
   input wire logic sda_level,
   input wire logic sda_oe,
   input wire logic irq_n,
   input wire logic byte_done_flag
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int QTR = (SYS_CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
   logic [15:0] rel_q;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // Cycles since the clock line was last pulled
   always_ff @(posedge clk) begin
      if (srst || scl_oe) begin
         rel_q <= 16'h0;
      end else if (rel_q != 16'hFFFF) begin
         rel_q <= rel_q + 16'h1;
      end
   end
   property p_open;
      scl_level == 1'h0 && sda_level == 1'h0;
   endproperty
   a_open: assert property (p_open) else $error("bus line driven high");
   property p_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_wait: assert property (p_wait) else $error("access not answered after one wait");
   property p_pulse;
      pready |=> !pready;
   endproperty
   a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
   property p_err;
      pready |-> pslverr == (paddr != 8'h00 && paddr != 8'h04 && paddr != 8'h08 && paddr != 8'h0C);
   endproperty
   a_err: assert property (p_err) else $error("error response wrong for address");
   property p_done;
      $rose(byte_done_flag) |-> !scl_sense;
   endproperty
   a_done: assert property (p_done) else $error("byte done while clock high");
   property p_irq;
      $rose(byte_done_flag) |-> ##[0:3] !irq_n;
   endproperty
   a_irq: assert property (p_irq) else $error("no low request after byte");
   property p_high;
      $rose(scl_oe) |-> rel_q >= 2 * QTR - 2;
   endproperty
   a_high: assert property (p_high) else $error("clock high phase too short");
   property p_start;
      $rose(sda_oe) && !scl_oe && scl_sense |-> $past(sda_sense) ##1 (!scl_oe) [*8];
   endproperty
   a_start: assert property (p_start) else $error("bad start condition");
   property p_stop;
      $fell(sda_oe) && !scl_oe && scl_sense |-> ##1 (!sda_oe && !scl_oe) [*8];
   endproperty
   a_stop: assert property (p_stop) else $error("bus not left free after stop");
endmodule : i2cme_chk

bind i2cme_engine i2cme_chk #(.SYS_CLK_HZ(SYS_CLK_HZ), .SCL_HZ(SCL_HZ)) chk_u (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .scl_sense(scl_sense), .scl_level(scl_level), .scl_oe(scl_oe), .sda_sense(sda_sense),
   .sda_level(sda_level), .sda_oe(sda_oe), .irq_n(irq_n), .byte_done_flag(byte_done_flag)
);

// ==== i2cme_slv.sv ====
// Purpose: behavioural slave on the two-wire bus
// Assumes: both lines pulled up
// Notes: only pulls data low, never holds the clock
module i2cme_slv #(
   parameter logic [6:0] ADDR = 7'h2A,
   parameter logic [7:0] TXB = 8'h3C
) (
   input wire logic scl,
   input wire logic sda,
   output logic sda_pull,
   output logic [7:0] rx_byte,
   output logic nack_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sr = 8'h0;
   logic [7:0] sh = 8'h0;
   logic act = 1'h0;
   logic rd = 1'h0;
   logic first = 1'h0;
   int bits = 0;
   initial begin
      sda_pull = 1'h0;
      rx_byte = 8'h0;
      nack_seen = 1'h0;
   end
   always @(negedge sda) begin
      if (scl) begin
         act = 1'h1;
         first = 1'h1;
         // Fall that ends START is not a bit
         bits = -1;
      end
   end
   always @(posedge sda) begin
      if (scl) begin
         act = 1'h0;
         sda_pull = 1'h0;
      end
   end
   always @(posedge scl) begin
      if (act && bits < 8) begin
         sr = {sr[6:0], sda};
      end else if (act && rd && !first && sda) begin
         act = 1'h0;
         nack_seen = 1'h1;
      end
   end
   always @(negedge scl) begin
      if (act) begin
         bits = bits + 1;
         if (bits == 8 && first) begin
            rd = sr[0];
            act = sr[7:1] == ADDR;
            sda_pull = act;
         end else if (bits == 8) begin
            rx_byte = rd ? rx_byte : sr;
            sda_pull = !rd;
         end else if (bits == 9) begin
            bits = 0;
            first = 1'h0;
            sh = TXB;
            sda_pull = rd && !sh[7];
         end else if (rd && !first) begin
            sda_pull = !sh[7 - bits];
         end
      end
   end
endmodule : i2cme_slv

// ==== tb.sv ====
// Purpose: self-checking bench of the two-wire bus engine
// Assumes: one slave model, pull-ups on both wires
// Notes: status bits as in the register map header
`include "i2cme_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] CT = `I2CME_OFF_CTRL;
   localparam logic [7:0] ST = `I2CME_OFF_STAT;
   localparam logic [7:0] OW = `I2CME_OFF_OWN;
   localparam logic [7:0] DT = `I2CME_OFF_DATA;
   localparam logic [31:0] ALL = 32'hFFFFFFFF;
   localparam logic [6:0] SADR = 7'h2A;
   localparam int QTR = (`I2CME_SYS_HZ + 4 * `I2CME_SCL_HZ - 1) / (4 * `I2CME_SCL_HZ);
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic ext_scl = 1'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, scl_oe, sda_oe, scl_level, sda_level, irq_n, byte_done_flag, sda_pull, nack_seen;
   logic [7:0] rx_byte;
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0;
   int last = 0;
   int per = 0;
   int npulse = 0;
   // Open-drain wires with pull-ups
   wire scl_w = !scl_oe && !ext_scl;
   wire sda_w = !sda_oe && !sda_pull;
   always #10 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge scl_w) begin
      per = cyc - last;
      last = cyc;
      npulse = npulse + 1;
   end
   i2cme_engine dut_u (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_sense(scl_w), .scl_level(scl_level), .scl_oe(scl_oe), .sda_sense(sda_w),
      .sda_level(sda_level), .sda_oe(sda_oe), .irq_n(irq_n), .byte_done_flag(byte_done_flag)
   );
   i2cme_slv #(.ADDR(SADR), .TXB(8'h3C)) slv_u (
      .scl(scl_w), .sda(sda_w), .sda_pull(sda_pull), .rx_byte(rx_byte), .nack_seen(nack_seen)
   );
   task automatic end_sim;
      $display("checks_done %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic hang;
      mismatches++;
      $display("[ERR] t=%0t wait limit reached", $time);
      end_sim();
   endtask : hang
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      if (pready !== 1'h1) begin
         hang();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'h1, a, d, r, e);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] r;
      logic e;
      apb(1'h0, a, 32'h0, r, e);
      chk(r & m, exp);
   endtask : rdc
   task automatic wait_done;
      int n = 0;
      repeat (4) @(posedge clk);
      while (byte_done_flag !== 1'h1 && n < 20000) begin
         @(posedge clk);
         n++;
      end
      if (byte_done_flag !== 1'h1) begin
         hang();
      end
   endtask : wait_done
   task automatic wait_free;
      logic [31:0] r;
      logic e;
      int n = 0;
      r = 32'h2;
      while (r[1] !== 1'h0 && n < 100) begin
         repeat (20) @(posedge clk);
         apb(1'h0, ST, 32'h0, r, e);
         n++;
      end
      if (r[1] !== 1'h0) begin
         hang();
      end
   endtask : wait_free
   initial begin
      logic [31:0] r;
      logic e;
      int n0;
      repeat (20) @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      chk({28'h0, irq_n, byte_done_flag, scl_oe, sda_oe}, 32'h8);
      rdc(CT, 32'h0, ALL);
      rdc(ST, 32'h0, ALL);
      rdc(OW, 32'h0, ALL);
      apb(1'h1, 8'h10, 32'hFF, r, e);
      chk({31'h0, e}, 32'h1);
      apb(1'h0, 8'h10, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
      wr(OW, 32'h66);
      rdc(OW, 32'h66, ALL);
      // Master write: address then one data byte
      wr(DT, {24'h0, SADR, 1'h0});
      wr(CT, 32'h7);
      wait_done();
      chk({31'h0, per >= 4 * QTR && per <= 4 * QTR + 8}, 32'h1);
      rdc(ST, 32'hC3, 32'hFF);
      chk({31'h0, irq_n}, 32'h0);
      wr(ST, 32'h40);
      @(posedge clk);
      chk({31'h0, irq_n}, 32'h1);
      n0 = npulse;
      wr(DT, 32'hA5);
      wait_done();
      chk(npulse - n0, 32'h9);
      chk({24'h0, rx_byte}, 32'hA5);
      // Repeated start, one byte read closed by NACK
      wr(CT, 32'h17);
      wr(DT, {24'h0, SADR, 1'h1});
      wait_done();
      rdc(ST, 32'h0, 32'h20);
      wr(CT, 32'hB);
      apb(1'h0, DT, 32'h0, r, e);
      wait_done();
      chk({31'h0, nack_seen}, 32'h1);
      wr(CT, 32'h9);
      rdc(DT, 32'h3C, 32'hFF);
      wait_free();
      rdc(ST, 32'h0, 32'h82);
      // Address nobody answers
      wr(DT, {24'h0, 7'h11, 1'h0});
      wr(CT, 32'h7);
      wait_done();
      rdc(ST, 32'h20, 32'h20);
      wr(CT, 32'h1);
      wait_free();
      // Start refused while another party holds the clock low
      ext_scl <= 1'h1;
      repeat (4) @(posedge clk);
      wr(CT, 32'h7);
      rdc(ST, 32'h48, 32'hC8);
      rdc(CT, 32'h1, 32'h3);
      chk({30'h0, sda_oe, irq_n}, 32'h0);
      ext_scl <= 1'h0;
      end_sim();
   end
endmodule : tb
